// file: fep_map.svh
// Purpose : Constants for the flash erase, program and protect sequencer
// Assumes : Core clock of 200 MHz
// Notes   : Times are given in their own unit; cycle counts derive from them
`ifndef FEP_MAP_SVH
`define FEP_MAP_SVH

// ************************************************************
// Command bytes
// ************************************************************
`define FEP_OP_CHIP_ERASE_B0  8'hC7
`define FEP_OP_CHIP_ERASE_B1  8'h94
`define FEP_OP_CHIP_ERASE_B2  8'h80
`define FEP_OP_CHIP_ERASE_B3  8'h9A
`define FEP_OP_PROG_THRU_BUF  8'h82
`define FEP_OP_PROT_PRE0      8'h3D
`define FEP_OP_PROT_PRE1      8'h2A
`define FEP_OP_PROT_PRE2      8'h7F
`define FEP_OP_PROT_ENABLE    8'hA9
`define FEP_OP_PROT_DISABLE   8'h9A

// ************************************************************
// Protection register encoding
// ************************************************************
`define FEP_PROT_BYTE_SEL     8'hFF
`define FEP_PROT_BYTE_CLR     8'h00
`define FEP_PROT_PAIR_SEL     2'h3
`define FEP_SEC0A_HI          7
`define FEP_SEC0B_HI          5

// ************************************************************
// Sizes and field positions
// ************************************************************
`define FEP_BUF_STD_LAST      9'h107
`define FEP_BUF_BIN_LAST      9'h0FF
`define FEP_STD_PAGE_LSB      9
`define FEP_BIN_PAGE_LSB      8
`define FEP_CMD_BYTES         3'h4
`define FEP_SECTORS           5

// ************************************************************
// Timing
// ************************************************************
`define FEP_CLK_PERIOD_PS     5000
`define FEP_CHIP_ERASE_US     2000
`define FEP_ERASE_PROG_US     40
`define FEP_WP_FILTER_NS      100
`define FEP_WP_FILTER_CYC     ((`FEP_WP_FILTER_NS * 1000) / `FEP_CLK_PERIOD_PS)

`endif

// file: fep_pkg.sv
// Purpose : Types for the flash erase, program and protect sequencer
// Assumes : Nothing beyond the constants header
// Notes   : Engine states only
package fep_pkg;
	typedef enum logic [1:0] {
		FEP_ENG_IDLE,
		FEP_ENG_CHIP_ERASE,
		FEP_ENG_PAGE_ERASE,
		FEP_ENG_PAGE_PROG
	} fep_eng_e;
endpackage

// file: fep_flash_seq.sv
// Purpose : Serial command front end, buffer and protection control of a flash
// Assumes : Host runs SPI mode 0 or 3; array logic reads the buffer on clk
// Notes   : Serial side runs on spi_sck, the rest on clk
`timescale 1ns/1ps
`default_nettype none
`include "fep_map.svh"

module fep_flash_seq #(
	parameter int unsigned CHIP_ERASE_CYCLES = (`FEP_CHIP_ERASE_US * 1000000) / `FEP_CLK_PERIOD_PS,
	parameter int unsigned ERASE_PROG_CYCLES = (`FEP_ERASE_PROG_US * 1000000) / `FEP_CLK_PERIOD_PS
) (
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        spi_sck,
	input  wire logic        spi_cs_n,
	input  wire logic        spi_si,
	input  wire logic        wp_n,
	input  wire logic        binary_page_size,
	input  wire logic [7:0]  prot_byte0,
	input  wire logic [7:0]  prot_byte1,
	input  wire logic [7:0]  prot_byte2,
	input  wire logic [7:0]  prot_byte3,
	input  wire logic [4:0]  sector_lock,
	input  wire logic [8:0]  buf_rd_addr,
	output logic      [7:0]  buf_rd_data_ff,
	output logic             status_busy_ff,
	output logic             status_protect_ff,
	output logic             prot_reg_writable_ff,
	output logic             arr_chip_erase_ff,
	output logic      [4:0]  arr_sector_mask_ff,
	output logic             arr_erase_page_ff,
	output logic             arr_program_page_ff,
	output logic      [8:0]  arr_page_ff
);
	import fep_pkg::*;

	localparam logic [19:0] CE_CNT = CHIP_ERASE_CYCLES[19:0];
	localparam logic [19:0] EP_CNT = ERASE_PROG_CYCLES[19:0];
	localparam logic [19:0] EP_HALF = EP_CNT >> 1;
	localparam int unsigned WPF_INT = `FEP_WP_FILTER_CYC;
	localparam logic [7:0] WPF_CNT = WPF_INT[7:0];

	// ************************************************************
	// Serial side on spi_sck
	// ************************************************************
	logic [2:0] bit_cnt_ff;
	logic [6:0] shift_ff;
	logic [7:0] link_byte_ff;
	logic       link_tog_ff;

	// Bit counter restarts whenever chip select is high
	always_ff @(posedge spi_sck or posedge spi_cs_n) begin
		if (spi_cs_n)
			bit_cnt_ff <= 3'h0;
		else
			bit_cnt_ff <= bit_cnt_ff + 3'h1;
	end

	// Shift serial input in, most significant bit first
	always_ff @(posedge spi_sck) begin
		shift_ff <= {shift_ff[5:0], spi_si};
	end

	// Hold each complete byte and flag it by a toggle
	always_ff @(posedge spi_sck or negedge reset_n) begin
		if (!reset_n) begin
			link_byte_ff <= 8'h00;
			link_tog_ff  <= 1'b0;
		end else if (bit_cnt_ff == 3'h7) begin
			link_byte_ff <= {shift_ff, spi_si};
			link_tog_ff  <= ~link_tog_ff;
		end
	end

	// ************************************************************
	// Crossing into clk
	// ************************************************************
	logic cs_s1_ff, cs_s2_ff, cs_s3_ff, cs_s4_ff;
	logic tog_s1_ff, tog_s2_ff, tog_s3_ff;
	logic wp_s1_ff, wp_s2_ff;
	logic byte_stb;
	logic cs_rise;

	// Two-stage synchronisers plus edge history
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			cs_s1_ff  <= 1'b1;
			cs_s2_ff  <= 1'b1;
			cs_s3_ff  <= 1'b1;
			cs_s4_ff  <= 1'b1;
			tog_s1_ff <= 1'b0;
			tog_s2_ff <= 1'b0;
			tog_s3_ff <= 1'b0;
			wp_s1_ff  <= 1'b1;
			wp_s2_ff  <= 1'b1;
		end else begin
			cs_s1_ff  <= spi_cs_n;
			cs_s2_ff  <= cs_s1_ff;
			cs_s3_ff  <= cs_s2_ff;
			cs_s4_ff  <= cs_s3_ff;
			tog_s1_ff <= link_tog_ff;
			tog_s2_ff <= tog_s1_ff;
			tog_s3_ff <= tog_s2_ff;
			wp_s1_ff  <= wp_n;       // Pad pull-up makes a floating pin read high
			wp_s2_ff  <= wp_s1_ff;
		end
	end

	assign byte_stb = tog_s2_ff ^ tog_s3_ff;
	// Late edge lets the last byte land first
	assign cs_rise  = cs_s3_ff & ~cs_s4_ff;

	// ************************************************************
	// Write-protect filter and protection state
	// ************************************************************
	logic [7:0] wpf_cnt_ff;
	logic       wp_filt_ff;
	logic       hw_prot_ff;
	logic       sw_prot_ff;
	logic       erasing;
	logic       prot_on;

	// Input must hold a new level for the whole window before it counts
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			wpf_cnt_ff <= 8'h00;
			wp_filt_ff <= 1'b0;
		end else if (wp_s2_ff == ~wp_filt_ff) begin
			wpf_cnt_ff <= 8'h00;
		end else if (wpf_cnt_ff == WPF_CNT - 8'h1) begin
			wpf_cnt_ff <= 8'h00;
			wp_filt_ff <= ~wp_s2_ff;
		end else begin
			wpf_cnt_ff <= wpf_cnt_ff + 8'h1;
		end
	end

	// Hardware protection follows the filtered pin, frozen during erase
	always_ff @(posedge clk) begin
		if (!reset_n)
			hw_prot_ff <= 1'b0;
		else if (!erasing)
			hw_prot_ff <= wp_filt_ff;
	end

	assign prot_on = sw_prot_ff | hw_prot_ff;

	// Status flags shown to the host
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			status_protect_ff    <= 1'b0;
			prot_reg_writable_ff <= 1'b1;
		end else begin
			status_protect_ff    <= prot_on;
			prot_reg_writable_ff <= ~hw_prot_ff;
		end
	end

	// ************************************************************
	// Sector selection
	// ************************************************************
	logic [4:0] sec_sel;
	logic [4:0] sec_guard;

	// Sectors 0a, 0b, 1, 2, 3 chosen by the protection register
	assign sec_sel[0] = prot_byte0[`FEP_SEC0A_HI -: 2] == `FEP_PROT_PAIR_SEL;
	assign sec_sel[1] = prot_byte0[`FEP_SEC0B_HI -: 2] == `FEP_PROT_PAIR_SEL;
	assign sec_sel[2] = prot_byte1 == `FEP_PROT_BYTE_SEL;
	assign sec_sel[3] = prot_byte2 == `FEP_PROT_BYTE_SEL;
	assign sec_sel[4] = prot_byte3 == `FEP_PROT_BYTE_SEL;
	// Guarded only when protection is on
	assign sec_guard = prot_on ? sec_sel : 5'h00;

	// Sector index of a page: 0a pages 0-7, 0b to 127, then 128 each
	function automatic logic [2:0] fep_page_sector(input logic [8:0] page);
		logic [2:0] idx;
		idx = 3'h0;
		if (page[8:7] != 2'h0)
			idx = {1'b0, page[8:7]} + 3'h1;
		else if (page[6:3] != 4'h0)
			idx = 3'h1;
		return idx;
	endfunction

	// ************************************************************
	// Command collection
	// ************************************************************
	logic [2:0]  byte_idx_ff;
	logic [7:0]  cmd0_ff, cmd1_ff, cmd2_ff, cmd3_ff;
	logic [8:0]  wr_ptr_ff;
	logic [7:0]  rx_byte_ff;
	logic [7:0]  buf_mem [0:263];
	logic        is_prog;
	logic        is_chip_erase;
	logic        is_prot_pre;
	logic        taking;
	logic [8:0]  buf_last;
	logic [23:0] addr_bits;
	logic [8:0]  tgt_page;
	logic [8:0]  tgt_off;

	assign taking   = byte_stb & ~cs_s2_ff & ~status_busy_ff;
	assign is_prog  = cmd0_ff == `FEP_OP_PROG_THRU_BUF;
	assign buf_last = binary_page_size ? `FEP_BUF_BIN_LAST : `FEP_BUF_STD_LAST;
	assign addr_bits = {cmd1_ff, cmd2_ff, cmd3_ff};
	// Address split by page size
	assign tgt_page = binary_page_size ? addr_bits[`FEP_BIN_PAGE_LSB +: 9]
	                                   : addr_bits[`FEP_STD_PAGE_LSB +: 9];
	assign tgt_off  = binary_page_size ? {1'b0, addr_bits[7:0]} : addr_bits[8:0];
	// Exact four-byte match; later bytes never reach the match
	assign is_chip_erase = byte_idx_ff == `FEP_CMD_BYTES &&
	                       cmd0_ff == `FEP_OP_CHIP_ERASE_B0 && cmd1_ff == `FEP_OP_CHIP_ERASE_B1 &&
	                       cmd2_ff == `FEP_OP_CHIP_ERASE_B2 && cmd3_ff == `FEP_OP_CHIP_ERASE_B3;
	assign is_prot_pre   = byte_idx_ff == `FEP_CMD_BYTES &&
	                       cmd0_ff == `FEP_OP_PROT_PRE0 && cmd1_ff == `FEP_OP_PROT_PRE1 &&
	                       cmd2_ff == `FEP_OP_PROT_PRE2;

	// First four bytes of a frame, count saturates at four
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			byte_idx_ff <= 3'h0;
			cmd0_ff     <= 8'h00;
			cmd1_ff     <= 8'h00;
			cmd2_ff     <= 8'h00;
			cmd3_ff     <= 8'h00;
		end else if (cs_s4_ff && cs_s3_ff) begin
			byte_idx_ff <= 3'h0;
		end else if (taking && byte_idx_ff != `FEP_CMD_BYTES) begin
			byte_idx_ff <= byte_idx_ff + 3'h1;
			case (byte_idx_ff)
				3'h0: cmd0_ff <= rx_byte_ff;
				3'h1: cmd1_ff <= rx_byte_ff;
				3'h2: cmd2_ff <= rx_byte_ff;
				default: cmd3_ff <= rx_byte_ff;
			endcase
		end
	end

	// Byte from the link, stable while its toggle is seen
	// Only this register reads the link byte on the clk side
	always_ff @(posedge clk) begin
		if (!reset_n)
			rx_byte_ff <= 8'h00;
		else
			rx_byte_ff <= link_byte_ff;
	end

	// The link byte holds for a whole byte time after its toggle moves,
	// so the copy above has settled before the synchronised toggle
	// reaches the strobe that uses it

	// Buffer fill from the start offset with wrap
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			wr_ptr_ff <= 9'h000;
		end else if (taking && byte_idx_ff == 3'h3) begin
			// Offset bit 8 sits in the previous address byte
			wr_ptr_ff <= binary_page_size ? {1'b0, rx_byte_ff} : {cmd2_ff[0], rx_byte_ff};
		end else if (taking && byte_idx_ff == `FEP_CMD_BYTES && is_prog) begin
			buf_mem[wr_ptr_ff] <= rx_byte_ff;
			wr_ptr_ff <= (wr_ptr_ff >= buf_last) ? 9'h000 : wr_ptr_ff + 9'h001;
		end
	end

	// Buffer read port for the array
	always_ff @(posedge clk) begin
		if (!reset_n)
			buf_rd_data_ff <= 8'h00;
		else if (buf_rd_addr <= `FEP_BUF_STD_LAST)
			buf_rd_data_ff <= buf_mem[buf_rd_addr];
		else
			buf_rd_data_ff <= 8'h00;
	end

	// Software enable, volatile and cleared by reset
	always_ff @(posedge clk) begin
		if (!reset_n)
			sw_prot_ff <= 1'b0;
		else if (cs_rise && !status_busy_ff && is_prot_pre) begin
			if (cmd3_ff == `FEP_OP_PROT_ENABLE)
				sw_prot_ff <= 1'b1;
			else if (cmd3_ff == `FEP_OP_PROT_DISABLE && !wp_filt_ff)
				sw_prot_ff <= 1'b0;
		end
	end

	// ************************************************************
	// Self-timed engine
	// ************************************************************
	fep_eng_e    eng_ff;
	logic [19:0] tmr_ff;
	logic        page_guarded;

	assign erasing = eng_ff == FEP_ENG_CHIP_ERASE || eng_ff == FEP_ENG_PAGE_ERASE;
	assign page_guarded = sec_guard[fep_page_sector(tgt_page)];

	// Engine sequencing and array strobes
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			eng_ff              <= FEP_ENG_IDLE;
			tmr_ff              <= 20'h00000;
			status_busy_ff      <= 1'b0;
			arr_chip_erase_ff   <= 1'b0;
			arr_sector_mask_ff  <= 5'h00;
			arr_erase_page_ff   <= 1'b0;
			arr_program_page_ff <= 1'b0;
			arr_page_ff         <= 9'h000;
		end else begin
			arr_chip_erase_ff   <= 1'b0;
			arr_erase_page_ff   <= 1'b0;
			arr_program_page_ff <= 1'b0;
			case (eng_ff)
				FEP_ENG_IDLE: begin
					tmr_ff <= 20'h00000;
					if (cs_rise && is_chip_erase) begin
						eng_ff             <= FEP_ENG_CHIP_ERASE;
						status_busy_ff     <= 1'b1;
						arr_chip_erase_ff  <= 1'b1;
						arr_sector_mask_ff <= ~(sec_guard | sector_lock);
					end else if (cs_rise && is_prog && byte_idx_ff == `FEP_CMD_BYTES &&
					             !page_guarded) begin
						eng_ff            <= FEP_ENG_PAGE_ERASE;
						status_busy_ff    <= 1'b1;
						arr_erase_page_ff <= 1'b1;
						arr_page_ff       <= tgt_page;
					end
				end
				FEP_ENG_CHIP_ERASE: begin
					tmr_ff <= tmr_ff + 20'h00001;
					if (tmr_ff == CE_CNT - 20'h00001) begin
						eng_ff         <= FEP_ENG_IDLE;
						status_busy_ff <= 1'b0;
					end
				end
				FEP_ENG_PAGE_ERASE: begin
					tmr_ff <= tmr_ff + 20'h00001;
					if (tmr_ff == EP_HALF - 20'h00001) begin
						eng_ff              <= FEP_ENG_PAGE_PROG;
						arr_program_page_ff <= 1'b1;
					end
				end
				default: begin
					tmr_ff <= tmr_ff + 20'h00001;
					if (tmr_ff == EP_CNT - 20'h00001) begin
						eng_ff         <= FEP_ENG_IDLE;
						status_busy_ff <= 1'b0;
					end
				end
			endcase
		end
	end

	logic unused_ok;
	assign unused_ok = &tgt_off;

endmodule // fep_flash_seq
`default_nettype wire

// file: fep_flash_seq_unused.sv
`timescale 1ns/1ps

// file: fep_flash_seq_asserts.sv
// Purpose : Port checker for the flash erase, program and protect sequencer
// Assumes : Bound to fep_flash_seq, clk domain only
// Notes   : Counts come from the bound parameters
`timescale 1ns/1ps
`default_nettype none
module fep_flash_seq_asserts #(
	parameter int unsigned CHIP_ERASE_CYCLES = 40,
	parameter int unsigned ERASE_PROG_CYCLES = 20
) (
	input wire logic       clk,
	input wire logic       reset_n,
	input wire logic       wp_n,
	input wire logic [4:0] sector_lock,
	input wire logic       status_busy_ff,
	input wire logic       status_protect_ff,
	input wire logic       prot_reg_writable_ff,
	input wire logic       arr_chip_erase_ff,
	input wire logic [4:0] arr_sector_mask_ff,
	input wire logic       arr_erase_page_ff,
	input wire logic       arr_program_page_ff
);
	localparam int CE1 = CHIP_ERASE_CYCLES - 1;
	localparam int EPH = ERASE_PROG_CYCLES / 2;
	localparam int EPR = ERASE_PROG_CYCLES - EPH;
	logic [5:0] hi_cnt_ff;
	logic       ce_run_ff;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	// Cycles with write-protect released and the engine not busy
	always_ff @(posedge clk) begin
		if (!reset_n || !wp_n || status_busy_ff)
			hi_cnt_ff <= 6'h00;
		else if (hi_cnt_ff != 6'h3F)
			hi_cnt_ff <= hi_cnt_ff + 6'h01;
	end
	// Chip erase in progress
	always_ff @(posedge clk) begin
		if (!reset_n)
			ce_run_ff <= 1'b0;
		else
			ce_run_ff <= arr_chip_erase_ff | (ce_run_ff & status_busy_ff);
	end
	property p_busy_cause;
		$rose(status_busy_ff) |-> arr_erase_page_ff || arr_chip_erase_ff;
	endproperty
	a_busy_cause: assert property (p_busy_cause) else $error("busy without start");
	property p_ce_len;
		arr_chip_erase_ff |-> ##CE1 status_busy_ff ##1 !status_busy_ff;
	endproperty
	a_ce_len: assert property (p_ce_len) else $error("chip erase busy length");
	property p_ep_walk;
		arr_erase_page_ff |-> status_busy_ff ##EPH arr_program_page_ff ##EPR !status_busy_ff;
	endproperty
	a_ep_walk: assert property (p_ep_walk) else $error("page erase program walk");
	property p_ce_idle;
		arr_chip_erase_ff |-> !$past(status_busy_ff);
	endproperty
	a_ce_idle: assert property (p_ce_idle) else $error("chip erase while busy");
	property p_mask_lock;
		arr_chip_erase_ff |-> (arr_sector_mask_ff & sector_lock) == 5'h00;
	endproperty
	a_mask_lock: assert property (p_mask_lock) else $error("locked sector erased");
	property p_hold_prot;
		ce_run_ff && status_busy_ff |-> $stable(prot_reg_writable_ff) && $stable(status_protect_ff);
	endproperty
	a_hold_prot: assert property (p_hold_prot) else $error("protection moved in erase");
	property p_wp_fell;
		$fell(prot_reg_writable_ff) |-> $past(wp_n, 2) == 1'b0 && $past(wp_n, 18) == 1'b0;
	endproperty
	a_wp_fell: assert property (p_wp_fell) else $error("protect on a glitch");
	property p_hw_status;
		$fell(prot_reg_writable_ff) |-> ##[0:2] status_protect_ff;
	endproperty
	a_hw_status: assert property (p_hw_status) else $error("status lacks protect");
	property p_release;
		hi_cnt_ff >= 6'h1E |-> prot_reg_writable_ff;
	endproperty
	a_release: assert property (p_release) else $error("read-only after release");
endmodule // fep_flash_seq_asserts
`default_nettype wire

// file: fep_spi_host.sv
// Purpose : Host controller model on the serial link
// Assumes : Mode 0, 48 ns clock period
// Notes   : Clock stands low outside frames
`timescale 1ns/1ps
`default_nettype none
module fep_spi_host (
	output logic spi_sck,
	output logic spi_cs_n,
	output logic spi_si
);
	initial begin
		spi_sck = 1'b0;
		spi_cs_n = 1'b1;
		spi_si = 1'b0;
	end
	// Sends whole bytes MSB first, then releases select
	task automatic send(input logic [7:0] q[$]);
		spi_cs_n = 1'b0;
		foreach (q[i]) for (int b = 7; b >= 0; b--) begin
			spi_si = q[i][b];
			#24 spi_sck = 1'b1;
			#24 spi_sck = 1'b0;
		end
		#24 spi_cs_n = 1'b1;
		spi_si = ~spi_si;
		#100;
	endtask
endmodule // fep_spi_host
`default_nettype wire

// file: fep_flash_seq_tb_top.sv
// Purpose : Self-checking bench of the flash sequencer
// Assumes : Short erase counts
// Notes   : Model holds buffer and protection state
`timescale 1ns/1ps
`default_nettype none
module fep_flash_seq_tb_top;
	localparam int CE = 100;
	localparam int EP = 20;
	logic       clk, reset_n, wp_n, bps, sw, hw;
	logic [4:0] lock, got_mask;
	logic [7:0] pb0, pb1, pb2, pb3, rd, q[$], exp_buf[264];
	logic [8:0] rd_a, got_page, pg;
	logic       busy, prot, wr, ce, ep, pp;
	logic [4:0] mask;
	logic [8:0] page;
	wire        sck, cs_n, si;
	logic [31:0] lfsr;
	int         err_count, n_compared, n_ce, n_pe, n_pp, busy_cyc;
	fep_spi_host host (.spi_sck(sck), .spi_cs_n(cs_n), .spi_si(si));
	fep_flash_seq #(.CHIP_ERASE_CYCLES(CE), .ERASE_PROG_CYCLES(EP)) uut (
		.clk(clk), .reset_n(reset_n), .spi_sck(sck), .spi_cs_n(cs_n), .spi_si(si),
		.wp_n(wp_n), .binary_page_size(bps), .prot_byte0(pb0), .prot_byte1(pb1),
		.prot_byte2(pb2), .prot_byte3(pb3), .sector_lock(lock), .buf_rd_addr(rd_a),
		.buf_rd_data_ff(rd), .status_busy_ff(busy), .status_protect_ff(prot),
		.prot_reg_writable_ff(wr), .arr_chip_erase_ff(ce), .arr_sector_mask_ff(mask),
		.arr_erase_page_ff(ep), .arr_program_page_ff(pp), .arr_page_ff(page));
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// Records array strobes and busy length
	always @(posedge clk) begin
		if (ce === 1'b1) begin n_ce++; got_mask = mask; end
		if (ep === 1'b1) begin n_pe++; got_page = page; end
		if (pp === 1'b1) n_pp++;
		if (busy === 1'b1) busy_cyc++;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin err_count++; $display("ERROR %s expected %0h seen %0h", nm, e, g); end
	endtask
	function automatic logic [7:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr[7:0];
	endfunction
	// Sectors guarded: 0a, 0b, 1, 2, 3
	function automatic logic [4:0] gmask();
		return (sw | hw) ? {pb3 == 8'hFF, pb2 == 8'hFF, pb1 == 8'hFF, pb0[5:4] == 2'h3,
			pb0[7:6] == 2'h3} : 5'h00;
	endfunction
	task automatic run();
		n_ce = 0; n_pe = 0; n_pp = 0; busy_cyc = 0;
		host.send(q);
		tick(10);
		for (int i = 0; i < 100 && busy !== 1'b0; i++) tick(1);
		$display("step done");
	endtask
	task automatic pchk();
		chk("protect", {31'h0, sw | hw}, {31'h0, prot});
		chk("writable", {31'h0, ~hw}, {31'h0, wr});
	endtask
	task automatic ce_chk(input bit e);
		chk("chip", e, n_ce);
		chk("busy", e ? CE : 0, busy_cyc);
		if (e) chk("mask", {27'h0, ~(gmask() | lock)}, {27'h0, got_mask});
	endtask
	// Program through buffer, then read back every byte written
	task automatic prog(input int off, input int n);
		logic [23:0] a;
		int          last, p, s;
		bit          gd;
		logic [4:0]  gm;
		last = bps ? 255 : 263;
		s = pg < 8 ? 0 : pg < 128 ? 1 : 1 + pg / 128;
		gm = gmask();
		gd = gm[s];
		a = bps ? {7'h00, pg, off[7:0]} : {6'h00, pg, off[8:0]};
		q = {8'h82, a[23:16], a[15:8], a[7:0]};
		p = off;
		repeat (n) begin q.push_back(rnd()); exp_buf[p] = q[$]; p = p == last ? 0 : p + 1; end
		run();
		chk("erase", !gd, n_pe);
		chk("program", !gd, n_pp);
		chk("busy", gd ? 0 : EP, busy_cyc);
		if (!gd) chk("page", {23'h0, pg}, {23'h0, got_page});
		p = off;
		repeat (n) begin
			rd_a = p[8:0];
			tick(2);
			chk("buf", {24'h0, exp_buf[p]}, {24'h0, rd});
			p = p == last ? 0 : p + 1;
		end
	endtask
	task automatic give_verdict();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		repeat (30000) @(posedge clk);
		err_count++;
		give_verdict();
	end
	initial begin
		lfsr = 32'd89356; wp_n = 1'b1; bps = 1'b0; lock = 5'h02; rd_a = 9'h000;
		pb0 = 8'hC0; pb1 = 8'hFF; pb2 = 8'h00; pb3 = 8'h17; sw = 0; hw = 0; reset_n = 1'b0;
		tick(4);
		reset_n = 1'b1;
		tick(30);
		pchk();
		q = {8'hC7, 8'h94, 8'h80, 8'h9A, 8'h55}; run(); ce_chk(1);
		q = {8'hC7, 8'h94, 8'h80, 8'h9B}; run(); ce_chk(0);
		q = {8'h3D, 8'h2A, 8'h7F, 8'hA9}; run(); sw = 1; pchk();
		q = {8'hC7, 8'h94, 8'h80, 8'h9A}; run(); ce_chk(1);
		pg = 9'd3; prog(262, 3);
		q = {8'h3D, 8'h2A, 8'h7F, 8'h9A}; run(); sw = 0; pchk();
		pg = {1'b1, rnd()}; prog(262, 4);
		bps = 1'b1; pg = {1'b0, rnd()}; prog(254, 3); bps = 1'b0;
		rd_a = 9'h1FF; tick(2); chk("buf_hi", 0, {24'h0, rd});
		wp_n = 1'b0; tick(5); wp_n = 1'b1; tick(30); pchk();
		wp_n = 1'b0; tick(30); hw = 1; pchk();
		pg = 9'd200; prog(0, 2);
		q = {8'h3D, 8'h2A, 8'h7F, 8'hA9}; run(); sw = 1;
		q = {8'h3D, 8'h2A, 8'h7F, 8'h9A}; run(); pchk();
		wp_n = 1'b1; tick(40); hw = 0; pchk();
		reset_n = 1'b0; tick(4); reset_n = 1'b1; sw = 0; tick(30); pchk();
		q = {8'h3D, 8'h2A, 8'h7F, 8'hA9}; run(); sw = 1; pchk();
		q = {8'h3D, 8'h2A, 8'h7F, 8'h9A}; run(); sw = 0; pchk();
		q = {8'hC7, 8'h94, 8'h80, 8'h9A}; host.send(q); tick(1);
		wp_n = 1'b0; tick(30); pchk(); chk("busy", 1, {31'h0, busy});
		tick(70); hw = 1; pchk();
		give_verdict();
	end
endmodule // fep_flash_seq_tb_top
bind fep_flash_seq fep_flash_seq_asserts #(
	.CHIP_ERASE_CYCLES(CHIP_ERASE_CYCLES), .ERASE_PROG_CYCLES(ERASE_PROG_CYCLES)) u_chk (
	.clk(clk), .reset_n(reset_n), .wp_n(wp_n), .sector_lock(sector_lock),
	.status_busy_ff(status_busy_ff), .status_protect_ff(status_protect_ff),
	.prot_reg_writable_ff(prot_reg_writable_ff), .arr_chip_erase_ff(arr_chip_erase_ff),
	.arr_sector_mask_ff(arr_sector_mask_ff), .arr_erase_page_ff(arr_erase_page_ff),
	.arr_program_page_ff(arr_program_page_ff));
`default_nettype wire
